// ---- inc/serial_unit_pkg.sv ----
/*
 * Constants for the serial unit register bank in SPI mode: offsets,
 * field positions, reset values, writable masks and selector codes.
 * Assumes a word-aligned 8-bit byte address on the register port.
 */
package serial_unit_pkg;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;

	// Byte offsets
	localparam logic [7:0] OFS_UNIT_CONTROL = 8'h00;
	localparam logic [7:0] OFS_TRANSMIT_WORD = 8'h30;
	localparam logic [7:0] OFS_RECEIVE_WORD = 8'h34;
	localparam logic [7:0] OFS_BUFFER_STATUS = 8'h3c;
	localparam logic [7:0] OFS_PROTOCOL_STATUS = 8'h64;

	// Plain read-write configuration registers
	localparam int NUM_CFG = 11;
	localparam int CFG_INTEN = 0;
	localparam int CFG_BAUD = 1;
	localparam int CFG_LINE = 5;
	localparam int CFG_PROTCTL = 8;
	localparam logic [7:0] CFG_OFFSET [NUM_CFG] = '{
		8'h04, 8'h08, 8'h10, 8'h20, 8'h28, 8'h2c,
		8'h38, 8'h54, 8'h5c, 8'h60, 8'h58};
	localparam logic [31:0] CFG_RESET [NUM_CFG] = '{
		32'h0000_0000, 32'h0000_3c00, 32'h0000_0000, 32'h0000_0000,
		32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
		32'h0000_0300, 32'h0000_0000, 32'h0000_0000};
	localparam logic [31:0] CFG_MASK [NUM_CFG] = '{
		32'h0000_001e, 32'h03ff_003f, 32'hffff_ffff, 32'hffff_ffff,
		32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff,
		32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff};

	// Unit control
	localparam int SEL_LSB = 0;
	localparam int SEL_W = 3;
	localparam logic [2:0] SEL_OFF = 3'h0;
	localparam logic [2:0] SEL_SPI = 3'h1;
	localparam logic [2:0] SEL_UART = 3'h2;
	localparam logic [2:0] SEL_I2C = 3'h4;
	localparam logic [2:0] SEL_IMPLEMENTED = 3'h1;
	localparam logic [31:0] UNIT_CONTROL_RESET = 32'h0000_0000;

	// Event flag positions in status and enable words
	localparam int FLG_W = 5;
	localparam int FLG_TX_BEGIN = 1;
	localparam int FLG_TX_FINISH = 2;
	localparam int FLG_RX_BEGIN = 3;
	localparam int FLG_RX_FINISH = 4;
	localparam logic [4:0] FLG_MASK = 5'h1e;

	localparam logic [31:0] BUFFER_STATUS_RESET = 32'h0000_0101;
	localparam logic [31:0] WORD_RESET = 32'h0000_0000;

	typedef enum {ST_OFF, ST_ON, ST_BLOCKED} unit_state_e;
endpackage

// ---- inc/event_bus_if.sv ----
/*
 * Carrier between the register bank and its event flag block.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
interface event_bus_if;
	import serial_unit_pkg::*;
	logic [FLG_W-1:0] setEvt;
	logic [FLG_W-1:0] clrMask;
	logic [FLG_W-1:0] enMask;
	logic [FLG_W-1:0] flags;
	logic clearAll;
	logic irq;
	modport bank (output setEvt, output clrMask, output enMask,
		output clearAll, input flags, input irq);
	modport flag (input setEvt, input clrMask, input enMask,
		input clearAll, output flags, output irq);
endinterface

// ---- design/event_flags.sv ----
/*
 * Sticky event flags with write-one-to-clear and a gated interrupt.
 * Assumes event pulses come from logic on the same clock.
 */
`timescale 1ns/10ps
module event_flags
	import serial_unit_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic ce,
	event_bus_if.flag ev
);
	logic [FLG_W-1:0] flags_ff;

	// One flop per flag; set beats a write-one clear, but clearAll beats set
	genvar i;
	generate
		for (i = 0; i < FLG_W; i++) begin : g_flag
			always_ff @(posedge clk_sys or negedge rstn) begin
				if (!rstn) begin
					flags_ff[i] <= 1'b0;
				end else if (ce) begin
					if (!FLG_MASK[i] || ev.clearAll) begin
						flags_ff[i] <= 1'b0;
					end else if (ev.setEvt[i]) begin
						flags_ff[i] <= 1'b1;
					end else if (ev.clrMask[i]) begin
						flags_ff[i] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	assign ev.flags = flags_ff;
	// Enables only gate the request, never the flag
	assign ev.irq = |(flags_ff & ev.enMask & FLG_MASK);
endmodule

// ---- design/serial_unit_spi_register_bank.sv ----
/*
 * Register bank of the serial unit in SPI mode: sixteen word
 * registers, the protocol selector, event flags and interrupt.
 * Assumes a single-cycle strobe master on clk_sys and a shifting
 * engine on the same clock that reports events as one-cycle pulses.
 */
`timescale 1ns/10ps
module serial_unit_spi_register_bank
	import serial_unit_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic ce,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [DATA_W-1:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [DATA_W-1:0] regRdData,
	input wire logic txBeginEvt,
	input wire logic txFinishEvt,
	input wire logic rxBeginEvt,
	input wire logic rxFinishEvt,
	input wire logic [DATA_W-1:0] rxWord,
	input wire logic rxWordValid,
	input wire logic [DATA_W-1:0] bufStatusIn,
	output logic [DATA_W-1:0] txWord,
	output logic txWordValid,
	output logic rxWordTaken,
	output logic [SEL_W-1:0] protoSelect,
	output logic spiEnable,
	output logic protoHoldIdle,
	output logic unitClear,
	output logic [DATA_W-1:0] baudGen,
	output logic [DATA_W-1:0] lineCtrl,
	output logic [DATA_W-1:0] protocolCtrl,
	output logic irq
);
	event_bus_if ev ();

	// Index of a plain configuration register, NUM_CFG when none
	function automatic int cfgIndex(input logic [ADDR_W-1:0] a);
		int idx;
		idx = NUM_CFG;
		for (int k = 0; k < NUM_CFG; k++) begin
			if (a == CFG_OFFSET[k]) begin
				idx = k;
			end
		end
		return idx;
	endfunction

	// True when a selector code names a protocol built into this unit
	function automatic logic selUsable(input logic [SEL_W-1:0] s);
		logic ok;
		ok = 1'b0;
		case (s)
			SEL_SPI: ok = SEL_IMPLEMENTED[0];
			SEL_UART: ok = SEL_IMPLEMENTED[1];
			SEL_I2C: ok = SEL_IMPLEMENTED[2];
			default: ok = 1'b0;
		endcase
		return ok;
	endfunction

	// True when an aligned bus address names the given word offset
	function automatic logic regHit(input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] ofs);
		logic hit;
		hit = (a[1:0] == 2'h0) && (a == ofs);
		return hit;
	endfunction

	// Bus decode
	logic aligned;
	logic wrSel;
	logic wrTx;
	logic rdRx;
	logic wrSts;
	logic [SEL_W-1:0] wrCode;
	int wrIdx;
	int rdIdx;

	// Selector, unit state and engine control
	logic [SEL_W-1:0] select_ff;
	logic [SEL_W-1:0] nxt_select;
	unit_state_e state_ff;
	unit_state_e nxt_state;
	logic unitClear_ff;
	logic spiEnable_ff;
	logic protoHoldIdle_ff;
	logic active;

	// Register storage and read path
	logic [DATA_W-1:0] cfg_ff [NUM_CFG];
	logic [DATA_W-1:0] txWord_ff;
	logic txWordValid_ff;
	logic [DATA_W-1:0] rxWord_ff;
	logic rxWordTaken_ff;
	logic [DATA_W-1:0] bufStatus_ff;
	logic [DATA_W-1:0] regRdData_ff;
	logic [DATA_W-1:0] nxt_rdData;

	// Address decode; misaligned addresses map to nothing
	assign aligned = (regAddr[1:0] == 2'h0);
	assign wrSel = regWr && regHit(regAddr, OFS_UNIT_CONTROL);
	assign wrTx = regWr && regHit(regAddr, OFS_TRANSMIT_WORD);
	assign rdRx = regRd && regHit(regAddr, OFS_RECEIVE_WORD);
	assign wrSts = regWr && regHit(regAddr, OFS_PROTOCOL_STATUS);
	assign wrCode = regWrData[SEL_LSB +: SEL_W];

	// Read and write share one configuration index
	assign wrIdx = aligned ? cfgIndex(regAddr) : NUM_CFG;
	assign rdIdx = wrIdx;

	// Next selector; upper control bits are never stored
	assign nxt_select = wrSel ? wrCode : select_ff;

	// Selector field
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			select_ff <= UNIT_CONTROL_RESET[SEL_W-1:0];
		end else if (ce) begin
			select_ff <= nxt_select;
		end
	end

	// Unit state: a new code while running blocks until off is written,
	// so a skipped off step cannot leave the engine half switched
	always_comb begin
		nxt_state = state_ff;
		if (wrSel) begin
			case (state_ff)
				ST_OFF: begin
					if (selUsable(regWrData[SEL_LSB +: SEL_W])) begin
						nxt_state = ST_ON;
					end else if (regWrData[SEL_LSB +: SEL_W] != SEL_OFF) begin
						nxt_state = ST_BLOCKED;
					end
				end
				ST_ON: begin
					if (regWrData[SEL_LSB +: SEL_W] == SEL_OFF) begin
						nxt_state = ST_OFF;
					end else if (regWrData[SEL_LSB +: SEL_W] != select_ff) begin
						nxt_state = ST_BLOCKED;
					end
				end
				ST_BLOCKED: begin
					if (regWrData[SEL_LSB +: SEL_W] == SEL_OFF) begin
						nxt_state = ST_OFF;
					end
				end
				default: nxt_state = ST_OFF;
			endcase
		end
	end

	// State register
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_ff <= ST_OFF;
		end else if (ce) begin
			state_ff <= nxt_state;
		end
	end

	// Engine control from flops, fed by the next state so both
	// change on the same edge as the state register itself
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			spiEnable_ff <= 1'b0;
			protoHoldIdle_ff <= 1'b1;
		end else if (ce) begin
			spiEnable_ff <= (nxt_state == ST_ON) &&
				(nxt_select == SEL_SPI);
			protoHoldIdle_ff <= (nxt_state != ST_ON);
		end
	end

	// Running only in the ON state
	assign active = (state_ff == ST_ON);

	// One-cycle clear pulse for the engine on every off write
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			unitClear_ff <= 1'b0;
		end else if (ce) begin
			unitClear_ff <= wrSel &&
				(regWrData[SEL_LSB +: SEL_W] == SEL_OFF);
		end
	end

	// Plain configuration registers with writable masks
	genvar g;
	generate
		for (g = 0; g < NUM_CFG; g++) begin : g_cfg
			always_ff @(posedge clk_sys or negedge rstn) begin
				if (!rstn) begin
					cfg_ff[g] <= CFG_RESET[g];
				end else if (ce && regWr && wrIdx == g) begin
					cfg_ff[g] <= regWrData & CFG_MASK[g];
				end
			end
		end
	endgenerate

	// Transmit word: stored on write, handed on only while running
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			txWord_ff <= WORD_RESET;
		end else if (ce) begin
			if (unitClear_ff) begin
				txWord_ff <= WORD_RESET;
			end else if (wrTx) begin
				txWord_ff <= regWrData;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			txWordValid_ff <= 1'b0;
		end else if (ce) begin
			txWordValid_ff <= wrTx && active;
		end
	end

	// Receive word: engine load wins over a clear in the same cycle
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rxWord_ff <= WORD_RESET;
		end else if (ce) begin
			if (rxWordValid && active) begin
				rxWord_ff <= rxWord;
			end else if (unitClear_ff) begin
				rxWord_ff <= WORD_RESET;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rxWordTaken_ff <= 1'b0;
		end else if (ce) begin
			rxWordTaken_ff <= rdRx;
		end
	end

	// Buffer status follows the engine only while running
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			bufStatus_ff <= BUFFER_STATUS_RESET;
		end else if (ce) begin
			if (!active) begin
				bufStatus_ff <= BUFFER_STATUS_RESET;
			end else begin
				bufStatus_ff <= bufStatusIn;
			end
		end
	end

	// Event hookup; events are ignored while the unit is idle
	always_comb begin
		ev.setEvt = '0;
		ev.setEvt[FLG_TX_BEGIN] = txBeginEvt && active;
		ev.setEvt[FLG_TX_FINISH] = txFinishEvt && active;
		ev.setEvt[FLG_RX_BEGIN] = rxBeginEvt && active;
		ev.setEvt[FLG_RX_FINISH] = rxFinishEvt && active;
	end
	assign ev.clrMask = wrSts ? regWrData[FLG_W-1:0] : '0;
	assign ev.enMask = cfg_ff[CFG_INTEN][FLG_W-1:0];
	assign ev.clearAll = unitClear_ff;

	// Sticky flags and the interrupt request
	event_flags u_flags (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.ce(ce),
		.ev(ev)
	);

	// Read mux; write-only and unmapped words read zero
	always_comb begin
		nxt_rdData = '0;
		if (aligned) begin
			if (rdIdx < NUM_CFG) begin
				nxt_rdData = cfg_ff[rdIdx];
			end else begin
				case (regAddr)
					OFS_UNIT_CONTROL: begin
						nxt_rdData[SEL_LSB +: SEL_W] = select_ff;
					end
					OFS_RECEIVE_WORD: nxt_rdData = rxWord_ff;
					OFS_BUFFER_STATUS: nxt_rdData = bufStatus_ff;
					OFS_PROTOCOL_STATUS: begin
						nxt_rdData[FLG_W-1:0] = ev.flags & FLG_MASK;
					end
					default: nxt_rdData = '0;
				endcase
			end
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			regRdData_ff <= '0;
		end else if (ce) begin
			regRdData_ff <= regRd ? nxt_rdData : '0;
		end
	end

	// Data path outputs
	assign regRdData = regRdData_ff;
	assign txWord = txWord_ff;
	assign txWordValid = txWordValid_ff;
	assign rxWordTaken = rxWordTaken_ff;

	// Engine control outputs
	assign protoSelect = select_ff;
	assign spiEnable = spiEnable_ff;
	assign protoHoldIdle = protoHoldIdle_ff;
	assign unitClear = unitClear_ff;

	// Configuration copies and interrupt request
	assign baudGen = cfg_ff[CFG_BAUD];
	assign lineCtrl = cfg_ff[CFG_LINE];
	assign protocolCtrl = cfg_ff[CFG_PROTCTL];
	assign irq = ev.irq;
endmodule

// ---- test/serial_unit_checker.sv ----
/* Port checker for the serial unit register bank.
 Assumes a bind onto the bank top module, one clock. */
`timescale 1ns/10ps
module serial_unit_checker
	import serial_unit_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [DATA_W-1:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [DATA_W-1:0] regRdData,
	input wire logic [DATA_W-1:0] txWord,
	input wire logic txWordValid,
	input wire logic rxWordTaken,
	input wire logic [SEL_W-1:0] protoSelect,
	input wire logic spiEnable,
	input wire logic protoHoldIdle,
	input wire logic unitClear,
	input wire logic [DATA_W-1:0] baudGen
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	// Off write, then the clear pulse while idle
	sequence offWrite;
		regWr && regAddr == 8'h00 && regWrData[2:0] == 3'h0;
	endsequence
	sequence clearIdle;
		unitClear && protoHoldIdle;
	endsequence
	a_off_clear: assert property (offWrite |=> clearIdle)
		else $error("no clear after off write");
	a_off_idle: assert property (protoSelect == 3'h0 |-> protoHoldIdle)
		else $error("unit not idle when off");
	a_spi_only: assert property (spiEnable |-> protoSelect == 3'h1)
		else $error("spi enabled with other code");
	// Read data stands one cycle only
	a_read_once: assert property (!$past(regRd) |-> regRdData == 32'h0)
		else $error("read data outside its cycle");
	a_tx_push: assert property (
		regWr && regAddr == 8'h30 && !protoHoldIdle
		|=> txWordValid && txWord == $past(regWrData))
		else $error("transmit word not pushed");
	a_tx_cause: assert property (txWordValid
		|-> $past(regWr) && $past(regAddr) == 8'h30)
		else $error("transmit pulse without write");
	a_tx_unread: assert property (regRd && regAddr == 8'h30
		|=> regRdData == 32'h0)
		else $error("transmit word readable");
	a_rx_taken: assert property (regRd && regAddr == 8'h34 |=> rxWordTaken)
		else $error("receive read not signalled");
	a_baud_mask: assert property (regWr && regAddr == 8'h08
		|=> baudGen == ($past(regWrData) & 32'h03ff_003f))
		else $error("baud reserved bits kept");
endmodule

// ---- test/tb_serial_unit_spi_register_bank.sv ----
/* Bench for the serial unit register bank: reset, map, selector,
 interrupts, data, freeze. Drives ce low in the freeze test; events driven here. */
`timescale 1ns/10ps
module tb_serial_unit_spi_register_bank;
	import serial_unit_pkg::*;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic ce = 1'b1;
	logic [7:0] regAddr = 8'h00;
	logic [31:0] regWrData = 32'h0;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [31:0] rxWord = 32'h0;
	logic rxWordValid = 1'b0;
	logic [31:0] bufStatusIn = 32'h0000_0a5a;
	logic [4:1] evt = 4'h0;
	logic [31:0] regRdData, txWord, baudGen, lineCtrl, protocolCtrl;
	logic txWordValid, rxWordTaken, spiEnable, protoHoldIdle;
	logic unitClear, irq;
	logic [2:0] protoSelect;
	int miscompares = 0;
	int checked = 0;
	serial_unit_spi_register_bank uut (.clk_sys(clk_sys), .rstn(rstn),
		.ce(ce), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
		.regRd(regRd), .regRdData(regRdData), .txBeginEvt(evt[1]),
		.txFinishEvt(evt[2]), .rxBeginEvt(evt[3]), .rxFinishEvt(evt[4]),
		.rxWord(rxWord), .rxWordValid(rxWordValid),
		.bufStatusIn(bufStatusIn), .txWord(txWord),
		.txWordValid(txWordValid), .rxWordTaken(rxWordTaken),
		.protoSelect(protoSelect), .spiEnable(spiEnable),
		.protoHoldIdle(protoHoldIdle), .unitClear(unitClear),
		.baudGen(baudGen), .lineCtrl(lineCtrl),
		.protocolCtrl(protocolCtrl), .irq(irq));
	// Free-running system clock
	initial begin
		forever #12.5 clk_sys = ~clk_sys;
	end
	task cmp(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task cmpb(input logic g, input logic e);
		cmp({31'h0, g}, {31'h0, e});
	endtask
	// Strobes rise after one edge and drop at the taking edge
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge clk_sys);
		regWr <= 1'b0;
		#1;
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_sys);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk_sys);
		regRd <= 1'b0;
		#1;
		cmp(regRdData, e);
	endtask
	task evp(input int b);
		@(posedge clk_sys);
		evt[b] <= 1'b1;
		@(posedge clk_sys);
		evt <= 4'h0;
		#1;
	endtask
	task t_reset;
		for (int i = 0; i < NUM_CFG; i++) rdc(CFG_OFFSET[i], CFG_RESET[i]);
		rdc(8'h08, 32'h0000_3c00);
		rdc(8'h5c, 32'h0000_0300);
		rdc(8'h30, 32'h0);
		rdc(8'h34, 32'h0);
		rdc(8'h3c, 32'h0000_0101);
		cmpb(protoHoldIdle, 1'b1);
		cmp(protocolCtrl, 32'h0000_0300);
		$display("test reset done");
	endtask
	task t_reserved;
		wr(8'h04, 32'hffff_ffff);
		rdc(8'h04, 32'h0000_001e);
		wr(8'h08, 32'hffff_ffff);
		rdc(8'h08, 32'h03ff_003f);
		wr(8'h34, 32'hffff_ffff);
		rdc(8'h34, 32'h0);
		wr(8'h3c, 32'hffff_ffff);
		rdc(8'h3c, 32'h0000_0101);
		wr(8'h0c, 32'hffff_ffff);
		rdc(8'h0c, 32'h0);
		rdc(8'h02, 32'h0);
		wr(8'h2c, 32'ha5a5_5a5a);
		cmp(lineCtrl, 32'ha5a5_5a5a);
		wr(8'h5c, 32'h0000_0001);
		cmp(protocolCtrl, 32'h0000_0001);
		wr(8'h04, 32'h0);
		$display("test reserved done");
	endtask
	// Every code, then a switch without the off write
	task t_select;
		for (int c = 0; c < 8; c++) begin
			wr(8'h00, 32'h0);
			cmpb(unitClear, 1'b1);
			wr(8'h00, 32'hffff_fff8 | 32'(c));
			rdc(8'h00, 32'(c));
			cmp(32'(protoSelect), 32'(c));
			cmpb(spiEnable, c == 1);
			cmpb(protoHoldIdle, c != 1);
		end
		wr(8'h00, 32'h0);
		wr(8'h00, 32'h1);
		wr(8'h00, 32'h2);
		cmpb(spiEnable, 1'b0);
		wr(8'h00, 32'h1);
		cmpb(spiEnable, 1'b0);
		wr(8'h00, 32'h0);
		wr(8'h00, 32'h1);
		cmpb(spiEnable, 1'b1);
		$display("test select done");
	endtask
	// Each enable gates its own event and not the next one (4 wraps to 1)
	task t_irq;
		int o;
		for (int b = 1; b < 5; b++) begin
			o = b % 4 + 1;
			wr(8'h04, 32'h1 << b);
			evp(o);
			cmpb(irq, 1'b0);
			evp(b);
			cmpb(irq, 1'b1);
			rdc(8'h64, (32'h1 << b) | (32'h1 << o));
			wr(8'h64, 32'h1 << b);
			cmpb(irq, 1'b0);
			wr(8'h64, 32'h1 << o);
		end
		evp(1);
		wr(8'h00, 32'h0);
		rdc(8'h64, 32'h0);
		evp(1);
		rdc(8'h64, 32'h0);
		$display("test irq done");
	endtask
	task t_data;
		wr(8'h00, 32'h1);
		@(posedge clk_sys);
		rxWord <= 32'h1234_5678;
		rxWordValid <= 1'b1;
		@(posedge clk_sys);
		rxWordValid <= 1'b0;
		rdc(8'h34, 32'h1234_5678);
		rdc(8'h3c, 32'h0000_0a5a);
		wr(8'h30, 32'hcafe_0001);
		cmp(txWord, 32'hcafe_0001);
		rdc(8'h30, 32'h0);
		wr(8'h00, 32'h0);
		rdc(8'h34, 32'h0);
		rdc(8'h3c, 32'h0000_0101);
		cmp(txWord, 32'h0);
		$display("test data done");
	endtask
	// Clock enable low: writes are dropped and all state holds
	task t_freeze;
		@(posedge clk_sys);
		ce <= 1'b0;
		wr(8'h2c, 32'h0000_0001);
		wr(8'h00, 32'h0000_0001);
		@(posedge clk_sys);
		ce <= 1'b1;
		cmp(lineCtrl, 32'ha5a5_5a5a);
		cmpb(protoHoldIdle, 1'b1);
		rdc(8'h00, 32'h0);
		$display("test freeze done");
	endtask
	task print_verdict;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// Main sequence, with a second reset after the last test
	initial begin
		repeat (6) @(posedge clk_sys);
		rstn <= 1'b1;
		t_reset();
		t_reserved();
		t_select();
		t_irq();
		t_data();
		t_freeze();
		wr(8'h08, 32'h1);
		@(posedge clk_sys);
		rstn <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rstn <= 1'b1;
		rdc(8'h08, 32'h0000_3c00);
		print_verdict();
	end
	// Run needs well under 2000 cycles
	initial begin
		#100us;
		miscompares++;
		print_verdict();
	end
endmodule
bind serial_unit_spi_register_bank serial_unit_checker chk (
	.clk_sys(clk_sys), .rstn(rstn), .regAddr(regAddr),
	.regWrData(regWrData), .regWr(regWr), .regRd(regRd),
	.regRdData(regRdData), .txWord(txWord), .txWordValid(txWordValid),
	.rxWordTaken(rxWordTaken), .protoSelect(protoSelect),
	.spiEnable(spiEnable), .protoHoldIdle(protoHoldIdle),
	.unitClear(unitClear), .baudGen(baudGen));
